// ### hdl/ifb_bank.sv
/*
 * Interrupt request flag and enable bank with an AXI4-Lite slave.
 * Assumes event inputs are one-cycle pulses synchronous to mclk, the CPU
 * sequencer pulses vectorServiced when it takes a vector, and the global
 * enable comes from outside this bank.
 */
`timescale 1ns/1ps
`default_nettype none
module ifb_bank (
	input  wire logic                          mclk,
	input  wire logic                          sys_rst,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	input  wire logic [ifb_pkg::AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	input  wire logic [ifb_pkg::AXI_DW-1:0]    s_axi_wdata,
	input  wire logic [ifb_pkg::STRB_W-1:0]    s_axi_wstrb,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	output var  logic [1:0]                    s_axi_bresp,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	input  wire logic [ifb_pkg::AXI_AW-1:0]    s_axi_araddr,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output var  logic [ifb_pkg::AXI_DW-1:0]    s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	input  wire logic [ifb_pkg::HALL_CH-1:0]   hallLevel,
	input  wire logic                          capMatchEvent,
	input  wire logic                          capOverflowEvent,
	input  wire logic                          adcLimitEvent,
	input  wire logic                          adcDoneEvent,
	input  wire logic                          pwmPeriodEvent,
	input  wire logic [ifb_pkg::PWM_CH-1:0]    pwmDutyEvent,
	input  wire logic [ifb_pkg::NUM_TIMERS-1:0] timerCmpAEvent,
	input  wire logic [ifb_pkg::NUM_TIMERS-1:0] timerCmpPEvent,
	input  wire logic                          timebaseEvent,
	input  wire logic                          eepromEvent,
	input  wire logic                          uartEvent,
	input  wire logic                          globalIrqEnable,
	input  wire logic [ifb_pkg::NUM_VEC-1:0]   vectorServiced,
	output var  logic [ifb_pkg::NUM_VEC-1:0]   irqRequest,
	output var  logic [1:0]                    groupLowPending
);
	import ifb_pkg::*;

	logic [REG_W-1:0]      regBank      [NUM_REGS];
	logic [REG_W-1:0]      next_regBank [NUM_REGS];
	logic [REG_W-1:0]      setBits      [NUM_REGS];
	logic [NUM_GROUPS-1:0] anyPend;
	logic [NUM_GROUPS-1:0] pendPrev;
	logic [NUM_GROUPS-1:0] next_pendPrev;
	logic [NUM_GROUPS-1:0] groupRise;
	logic [NUM_VEC-1:0]    next_irqRequest;
	logic [1:0]            next_groupLowPending;

	logic                  next_awready;
	logic                  next_wready;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic [AXI_AW-1:0]     awAddr;
	logic [AXI_AW-1:0]     next_awAddr;
	logic [AXI_DW-1:0]     wData;
	logic [AXI_DW-1:0]     next_wData;
	logic [STRB_W-1:0]     wStrb;
	logic [STRB_W-1:0]     next_wStrb;
	logic                  next_arready;
	logic                  next_rvalid;
	logic [AXI_DW-1:0]     next_rdata;
	logic [1:0]            next_rresp;
	logic                  doWrite;
	logic [IDX_W:0]        wrDec;
	logic [IDX_W:0]        rdDec;

	ifb_hall_if hallBus ();

	function automatic logic [IDX_W:0] decodeAddr(input logic [AXI_AW-1:0] a);
		logic [AXI_AW-3:0] word;
		word = a[AXI_AW-1:2];
		if (a[1:0] != ALIGN_ZERO)
			return '0;
		else if (word < NUM_REGS)
			return {1'b1, word[IDX_W-1:0]};
		else
			return '0;
	endfunction

	assign hallBus.level   = hallLevel;
	assign hallBus.edgeSel = regBank[IDX_EDGE_SEL][HALL_CH*EDGE_W-1:0];

	ifb_hall_edge u_hall_edge (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.hall    (hallBus.detector)
	);

	// Groups 0..6 map onto the hall..timer3 registers in address order
	always_comb begin
		for (int g = 0; g < NUM_GROUPS; g++) begin
			anyPend[g] = |pending(regBank[IDX_MF_HALL + g]);
		end
		next_pendPrev = anyPend;
		// Edge of the pending level, so a serviced group does not re-fire at once
		groupRise = anyPend & ~pendPrev;
	end

	// Events set flags whatever their enable says
	always_comb begin
		setBits[IDX_CTRL2]     = flagsAt(groupRise[5:2]);
		setBits[IDX_CTRL3]     = flagsAt({timebaseEvent, groupRise[6], eepromEvent,
			uartEvent});
		setBits[IDX_MF_HALL]   = flagsAt({1'b0, hallBus.hit});
		setBits[IDX_MF_CAPADC] = flagsAt({capMatchEvent, capOverflowEvent, adcLimitEvent,
			adcDoneEvent});
		setBits[IDX_MF_PWM]    = flagsAt({pwmPeriodEvent, pwmDutyEvent});
		setBits[IDX_MF_TIMER2] = flagsAt({2'h0, timerCmpAEvent[2], timerCmpPEvent[2]});
		setBits[IDX_MF_TIMER0] = flagsAt({2'h0, timerCmpAEvent[0], timerCmpPEvent[0]});
		setBits[IDX_MF_TIMER1] = flagsAt({2'h0, timerCmpAEvent[1], timerCmpPEvent[1]});
		setBits[IDX_MF_TIMER3] = flagsAt({2'h0, timerCmpAEvent[3], timerCmpPEvent[3]});
		setBits[IDX_EDGE_SEL]  = REG_RESET;
	end

	// Write first, then service clear, then set: an event in the clearing cycle wins
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			next_regBank[i] = regBank[i];
			if (doWrite && wrDec[IDX_W] && wrDec[IDX_W-1:0] == i && wStrb[0])
				next_regBank[i] = wData[REG_W-1:0] & regMask(IDX_W'(i));
		end
		next_regBank[IDX_CTRL2] = next_regBank[IDX_CTRL2]
			& ~flagsAt(vectorServiced[HALF_W-1:0]);
		next_regBank[IDX_CTRL3] = next_regBank[IDX_CTRL3]
			& ~flagsAt(vectorServiced[NUM_VEC-1:HALF_W]);
		for (int i = 0; i < NUM_REGS; i++) begin
			next_regBank[i] = next_regBank[i] | setBits[i];
		end
	end

	// Request needs flag, enable and global enable together
	always_comb begin
		next_irqRequest = {pending(regBank[IDX_CTRL3]), pending(regBank[IDX_CTRL2])}
			& {NUM_VEC{globalIrqEnable}};
		next_groupLowPending = anyPend[1:0];
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regBank[i] <= REG_RESET;
			end
			pendPrev <= '0;
			irqRequest <= '0;
			groupLowPending <= '0;
		end else begin
			regBank <= next_regBank;
			pendPrev <= next_pendPrev;
			irqRequest <= next_irqRequest;
			groupLowPending <= next_groupLowPending;
		end
	end

	// Write path: address and data are parked until both are held
	always_comb begin
		doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
		wrDec = decodeAddr(awAddr);
		next_awready = s_axi_awready;
		next_wready = s_axi_wready;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awready = 1'b0;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wready = 1'b0;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_bvalid = 1'b1;
			next_bresp = wrDec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
	end

	// Read path: one read in flight, answered in the cycle after the address
	always_comb begin
		rdDec = decodeAddr(s_axi_araddr);
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = '0;
			next_rresp = RESP_SLVERR;
			if (rdDec[IDX_W]) begin
				next_rdata = {{(AXI_DW-REG_W){1'b0}}, regBank[rdDec[IDX_W-1:0]]};
				next_rresp = RESP_OKAY;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awAddr <= '0;
			wData <= '0;
			wStrb <= '0;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	sequence capMatchSeen;
		capMatchEvent;
	endsequence

	sequence pwmGroupRises;
		anyPend[2] && !pendPrev[2];
	endsequence

	sequence ctrl2FullWrite;
		doWrite && wrDec == {1'b1, IDX_CTRL2} && wStrb[0] && vectorServiced == '0
			&& groupRise == '0;
	endsequence

	AST_HALL_RESERVED: assert property (@(posedge mclk) disable iff (sys_rst)
		!regBank[IDX_MF_HALL][BIT_HALL_RSV_H] && !regBank[IDX_MF_HALL][BIT_HALL_RSV_L])
		else $error("Hall register reserved bit is set");

	AST_TIMER_RESERVED: assert property (@(posedge mclk) disable iff (sys_rst)
		(regBank[IDX_MF_TIMER2] & ~MASK_TIMER) == REG_RESET
		&& (regBank[IDX_MF_TIMER3] & ~MASK_TIMER) == REG_RESET)
		else $error("Timer register reserved bits are set");

	AST_EVENT_SETS: assert property (@(posedge mclk) disable iff (sys_rst)
		capMatchSeen |=> regBank[IDX_MF_CAPADC][BIT_CAP_MATCH])
		else $error("Capture match event did not set its flag");

	AST_GROUP_SET: assert property (@(posedge mclk) disable iff (sys_rst)
		pwmGroupRises |=> regBank[IDX_CTRL2][BIT_G2_FLAG] ##1 1'b1)
		else $error("Group 2 flag missed an enabled PWM source");

	AST_SVC_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
		vectorServiced[VEC_G2] && !groupRise[2] |=> !regBank[IDX_CTRL2][BIT_G2_FLAG])
		else $error("Servicing group 2 did not clear its flag");

	AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (sys_rst)
		!globalIrqEnable ##1 !globalIrqEnable |-> irqRequest == '0)
		else $error("Request raised with global enable clear");

	AST_IRQ_FOLLOW: assert property (@(posedge mclk) disable iff (sys_rst)
		regBank[IDX_CTRL3][BIT_TB_FLAG] && regBank[IDX_CTRL3][BIT_TB_EN] && globalIrqEnable
		|=> irqRequest[VEC_TB])
		else $error("Enabled time base flag gave no request");

	AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (sys_rst)
		ctrl2FullWrite |=> regBank[IDX_CTRL2] == $past(wData[REG_W-1:0]) && s_axi_bvalid)
		else $error("Control write not stored");

	sequence readTaken;
		s_axi_arvalid && s_axi_arready && rdDec[IDX_W];
	endsequence

	AST_RESET_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
		$past(sys_rst) |-> regBank[IDX_CTRL2] == REG_RESET && regBank[IDX_CTRL3] == REG_RESET
		&& irqRequest == '0)
		else $error("Registers not clear after reset");

	AST_TB_SET_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
		timebaseEvent |=> regBank[IDX_CTRL3][BIT_TB_FLAG])
		else $error("Time base event did not set its flag");

	AST_TB_SVC_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
		vectorServiced[VEC_TB] && !timebaseEvent |=> !regBank[IDX_CTRL3][BIT_TB_FLAG])
		else $error("Servicing the time base did not clear its flag");

	AST_HALL_SET: assert property (@(posedge mclk) disable iff (sys_rst)
		hallBus.hit[0] |=> regBank[IDX_MF_HALL][HALF_W])
		else $error("Hall A hit did not set its flag");

	AST_READ_ANSWER: assert property (@(posedge mclk) disable iff (sys_rst)
		readTaken |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
		&& s_axi_rdata[AXI_DW-1:REG_W] == '0)
		else $error("Register read gave a bad answer");

	AST_WRITE_RESP: assert property (@(posedge mclk) disable iff (sys_rst)
		doWrite |=> s_axi_bvalid && (s_axi_bresp == RESP_OKAY) == $past(wrDec[IDX_W]))
		else $error("Write response does not match the address");
endmodule
`default_nettype wire

// ### hdl/ifb_pkg.sv
/*
 * Constants, field layouts and helper functions for the interrupt
 * flag and enable bank. Assumes one 50 MHz clock; every register is one
 * byte at a word-aligned AXI4-Lite address.
 */
package ifb_pkg;
	localparam int NUM_REGS   = 10;
	localparam int IDX_W      = 4;
	localparam int REG_W      = 8;
	localparam int HALF_W     = 4;
	localparam int NUM_GROUPS = 7;
	localparam int NUM_TIMERS = 4;
	localparam int HALL_CH    = 3;
	localparam int PWM_CH     = 3;
	localparam int NUM_VEC    = 8;
	localparam int EDGE_W     = 2;
	localparam int AXI_AW     = 32;
	localparam int AXI_DW     = 32;
	localparam int STRB_W     = 4;

	localparam logic [IDX_W-1:0] IDX_CTRL2      = 4'h0;
	localparam logic [IDX_W-1:0] IDX_CTRL3      = 4'h1;
	localparam logic [IDX_W-1:0] IDX_MF_HALL    = 4'h2;
	localparam logic [IDX_W-1:0] IDX_MF_CAPADC  = 4'h3;
	localparam logic [IDX_W-1:0] IDX_MF_PWM     = 4'h4;
	localparam logic [IDX_W-1:0] IDX_MF_TIMER2  = 4'h5;
	localparam logic [IDX_W-1:0] IDX_MF_TIMER0  = 4'h6;
	localparam logic [IDX_W-1:0] IDX_MF_TIMER1  = 4'h7;
	localparam logic [IDX_W-1:0] IDX_MF_TIMER3  = 4'h8;
	localparam logic [IDX_W-1:0] IDX_EDGE_SEL   = 4'h9;

	localparam logic [REG_W-1:0] REG_RESET   = 8'h00;
	localparam logic [REG_W-1:0] MASK_FULL   = 8'hff;
	localparam logic [REG_W-1:0] MASK_HALL   = 8'h77;
	localparam logic [REG_W-1:0] MASK_TIMER  = 8'h33;
	localparam logic [REG_W-1:0] MASK_EDGE   = 8'h3f;
	localparam logic [1:0]       ALIGN_ZERO  = 2'h0;
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;

	localparam int BIT_G2_FLAG    = 4;
	localparam int BIT_TB_FLAG    = 7;
	localparam int BIT_TB_EN      = 3;
	localparam int BIT_CAP_MATCH  = 7;
	localparam int BIT_HALL_RSV_H = 7;
	localparam int BIT_HALL_RSV_L = 3;
	localparam int VEC_G2         = 0;
	localparam int VEC_TB         = 7;

	typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} ifb_edge_t;

	function automatic logic [REG_W-1:0] regMask(input logic [IDX_W-1:0] idx);
		if (idx == IDX_MF_HALL)
			return MASK_HALL;
		else if (idx >= IDX_MF_TIMER2 && idx <= IDX_MF_TIMER3)
			return MASK_TIMER;
		else if (idx == IDX_EDGE_SEL)
			return MASK_EDGE;
		else
			return MASK_FULL;
	endfunction

	// Flag nibble sits four bits above its enable nibble in every register but edge select
	function automatic logic [HALF_W-1:0] pending(input logic [REG_W-1:0] r);
		return r[REG_W-1:HALF_W] & r[HALF_W-1:0];
	endfunction

	function automatic logic [REG_W-1:0] flagsAt(input logic [HALF_W-1:0] f);
		return {f, {HALF_W{1'b0}}};
	endfunction
endpackage

// ### hdl/ifb_hall_if.sv
/*
 * Carries filtered Hall levels and edge selection to the edge detector
 * and its one-cycle hit pulses back. Assumes both ends share mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface ifb_hall_if;
	logic [ifb_pkg::HALL_CH-1:0]                  level;
	logic [ifb_pkg::HALL_CH*ifb_pkg::EDGE_W-1:0]  edgeSel;
	logic [ifb_pkg::HALL_CH-1:0]                  hit;
	modport detector (input level, input edgeSel, output hit);
	modport bank (output level, output edgeSel, input hit);
endinterface
`default_nettype wire

// ### hdl/ifb_hall_edge.sv
/*
 * Hall edge detector: one registered hit pulse per selected edge.
 * Assumes the filtered Hall levels are synchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ifb_hall_edge (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	ifb_hall_if.detector      hall
);
	import ifb_pkg::*;

	logic [HALL_CH-1:0] levelPrev;
	logic [HALL_CH-1:0] next_levelPrev;
	logic [HALL_CH-1:0] hitReg;
	logic [HALL_CH-1:0] next_hitReg;
	logic               primed;
	logic               next_primed;

	function automatic logic edgeHit(input ifb_edge_t sel, input logic prev, input logic now);
		case (sel)
			EDGE_RISE: return !prev && now;
			EDGE_FALL: return prev && !now;
			EDGE_BOTH: return prev != now;
			default:   return 1'b0;
		endcase
	endfunction

	// No edge is reported until one level has been seen after reset
	always_comb begin
		next_levelPrev = hall.level;
		next_primed = 1'b1;
		for (int c = 0; c < HALL_CH; c++) begin
			next_hitReg[c] = primed && edgeHit(ifb_edge_t'(hall.edgeSel[c*EDGE_W +: EDGE_W]),
				levelPrev[c], hall.level[c]);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			levelPrev <= '0;
			hitReg <= '0;
			primed <= 1'b0;
		end else begin
			levelPrev <= next_levelPrev;
			hitReg <= next_hitReg;
			primed <= next_primed;
		end
	end

	assign hall.hit = hitReg;

	AST_HALL_EDGE: assert property (@(posedge mclk) disable iff (sys_rst)
		primed && hall.edgeSel[1:0] == 2'h1 && !levelPrev[0] && hall.level[0] |=> hall.hit[0])
		else $error("Hall A rising edge gave no hit");
endmodule
`default_nettype wire

// ### verification/ifb_event_src.sv
/*
 * Model of the peripheral event sources, the Hall filter outputs and
 * the CPU vector sequencer. Assumes the bench raises a request bit for
 * one cycle and holds Hall levels for as long as it wants them.
 */
`timescale 1ns/1ps
`default_nettype none
module ifb_event_src (
	input  wire logic        mclk,
	input  wire logic [18:0] strike,
	input  wire logic [7:0]  svcReq,
	input  wire logic [2:0]  hallReq,
	output var  logic [18:0] ev,
	output var  logic [7:0]  svc,
	output var  logic [2:0]  hall
);
	// Registered so each event and service request leaves as a clean one-cycle pulse
	always @(posedge mclk) begin
		ev <= strike;
		svc <= svcReq;
		hall <= hallReq;
	end
endmodule
`default_nettype wire

// ### verification/test_irq_flag_enable_bank.sv
/*
 * Self-checking bench for the interrupt flag and enable bank.
 * Assumes the event source model and the register bus timing of the
 * design's hand-over; reads and write responses are checked from queues.
 */
`timescale 1ns/1ps
`default_nettype none
module test_irq_flag_enable_bank;
	import ifb_pkg::*;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [31:0] awaddr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] araddr = '0;
	logic [3:0]  wstrb = 4'hf;
	logic        gie = 1'b0;
	logic [18:0] strike = '0;
	logic [7:0]  svcReq = '0;
	logic [2:0]  hallReq = '0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, lowPend;
	logic [31:0] rdata;
	logic [18:0] ev;
	logic [7:0]  svc, irq, v;
	logic [2:0]  hall;
	logic [33:0] rq[$];
	logic [1:0]  wq[$];
	int          n_fail = 0;
	int          check_count = 0;
	int          seed = 62;
	logic [7:0]  msk[10] = '{8'hff, 8'hff, 8'h77, 8'hff, 8'hff,
		8'h33, 8'h33, 8'h33, 8'h33, 8'h3f};
	// Register index and flag position reached by each event bit
	int          evIdx[19] = '{3, 3, 3, 3, 4, 4, 4, 4, 6, 7, 5, 8, 6, 7, 5, 8, 1, 1, 1};
	logic [7:0]  evVal[19] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h80, 8'h10, 8'h20,
		8'h40, 8'h20, 8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h10,
		8'h80, 8'h20, 8'h10};

	always #10 mclk = ~mclk;

	ifb_event_src src (.mclk(mclk), .strike(strike), .svcReq(svcReq), .hallReq(hallReq),
		.ev(ev), .svc(svc), .hall(hall));

	ifb_bank dut (.mclk(mclk), .sys_rst(sys_rst),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .hallLevel(hall),
		.capMatchEvent(ev[0]), .capOverflowEvent(ev[1]), .adcLimitEvent(ev[2]),
		.adcDoneEvent(ev[3]), .pwmPeriodEvent(ev[4]), .pwmDutyEvent(ev[7:5]),
		.timerCmpAEvent(ev[11:8]), .timerCmpPEvent(ev[15:12]),
		.timebaseEvent(ev[16]), .eepromEvent(ev[17]), .uartEvent(ev[18]),
		.globalIrqEnable(gie), .vectorServiced(svc), .irqRequest(irq),
		.groupLowPending(lowPend));

	task automatic cmpVal(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmpResp(input string nm, input logic [1:0] e, input logic [1:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test;
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input int i, input logic [7:0] d, input logic [1:0] r);
		logic a, w;
		wq.push_back(r);
		awaddr <= 32'(i * 4);
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a = 1'b1;
		w = 1'b1;
		while (a || w) begin
			@(posedge mclk);
			if (a && awready) begin
				a = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (!bvalid);
		bready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input int i, input logic [7:0] e, input logic [1:0] r);
		rq.push_back({r, 24'h0, e});
		araddr <= 32'(i * 4);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge mclk); while (!rvalid);
		rready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic pulse(input logic [18:0] e, input logic [7:0] s);
		strike <= e;
		svcReq <= s;
		@(posedge mclk);
		strike <= '0;
		svcReq <= '0;
		repeat (3) @(posedge mclk);
	endtask

	// Results are matched in arrival order against the notes left by the drivers
	always @(posedge mclk) begin
		if (rvalid && rready) begin
			cmpVal("rdata", rq[0][31:0], rdata);
			cmpResp("rresp", rq[0][33:32], rresp);
			void'(rq.pop_front());
		end
		if (bvalid && bready) begin
			cmpResp("bresp", wq[0], bresp);
			void'(wq.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 10; i++)
			rd(i, 8'h00, RESP_OKAY);
		rd(10, 8'h00, RESP_SLVERR);
		wr(10, 8'h5a, RESP_SLVERR);
		for (int i = 0; i < 10; i++) begin
			v = 8'($random(seed));
			wr(i, v, RESP_OKAY);
			rd(i, v & msk[i], RESP_OKAY);
			wr(i, 8'hff, RESP_OKAY);
			rd(i, msk[i], RESP_OKAY);
			wr(i, 8'h00, RESP_OKAY);
		end
		wr(0, 8'h00, RESP_OKAY);
		// Timer 3 writes above raised the group 6 flag in the third control register
		wr(1, 8'h00, RESP_OKAY);
		for (int b = 0; b < 19; b++) begin
			pulse(19'(1) << b, 8'h00);
			rd(evIdx[b], evVal[b], RESP_OKAY);
			wr(evIdx[b], 8'h00, RESP_OKAY);
		end
		rd(0, 8'h00, RESP_OKAY);
		pulse(19'h70000, 8'h00);
		wr(1, 8'hbb, RESP_OKAY);
		cmpVal("irqRequest", 32'h0, {24'h0, irq});
		gie <= 1'b1;
		repeat (2) @(posedge mclk);
		cmpVal("irqRequest", 32'hb0, {24'h0, irq});
		pulse(19'h0, 8'h80);
		rd(1, 8'h3b, RESP_OKAY);
		wr(1, 8'h00, RESP_OKAY);
		pulse(19'h00400, 8'h00);
		wr(5, 8'h22, RESP_OKAY);
		rd(0, 8'h20, RESP_OKAY);
		wr(0, 8'h22, RESP_OKAY);
		cmpVal("irqRequest", 32'h2, {24'h0, irq});
		pulse(19'h0, 8'h02);
		rd(0, 8'h02, RESP_OKAY);
		rd(5, 8'h22, RESP_OKAY);
		wr(9, 8'h39, RESP_OKAY);
		wr(2, 8'h01, RESP_OKAY);
		hallReq <= 3'h7;
		repeat (4) @(posedge mclk);
		rd(2, 8'h51, RESP_OKAY);
		cmpVal("groupLowPending", 32'h1, {30'h0, lowPend});
		hallReq <= 3'h0;
		repeat (4) @(posedge mclk);
		rd(2, 8'h71, RESP_OKAY);
		wr(3, 8'h88, RESP_OKAY);
		cmpVal("groupLowPending", 32'h3, {30'h0, lowPend});
		wr(4, 8'h11, RESP_OKAY);
		rd(0, 8'h12, RESP_OKAY);
		pulse(19'h0, 8'h01);
		rd(0, 8'h02, RESP_OKAY);
		end_of_test();
	end
endmodule
`default_nettype wire
